/* rtl/brp_pkg.sv */
// Purpose: shared constants and types of the read prefetch sizing block
// Assumes: register indexes are multiplied by four to form AHB byte addresses
// Notes:   count fields hold double words; bit 0 of every count is always zero
//
// Functional notes
// R1: the primary port fetches ahead the primary first-fetch length for a prefetchable read.
// R2: the secondary port fetches ahead the secondary first-fetch length for such a read.
// R3: every count field is a number of double words, not bytes.
// R4: software should program first and top-up lengths as powers of two.
// R5: bit 0 of every count field reads zero and ignores writes.
// R6: bits 7-6 of every count register are reserved and read zero.
// R7: when an entry's remaining count drops below the top-up length, one more top-up is fetched.
// R8: on the primary port no top-up is done if the top-up length exceeds half the primary cap.
// R9: on the secondary port no top-up is done if the top-up length exceeds half the secondary cap.
// R10: without flow-through, a primary entry's total fetch is capped at the primary cap.
// R11: a cap field of zero means the largest limit, 256 bytes.
// R12: software should program each cap with an even value.
// R13: first-fetch and top-up fields of both ports reset to 10h double words.
// R14: the primary cap resets to 20h double words.
// R15: without flow-through, a secondary entry's total is capped at the secondary cap, reset 20h.
// R16: a top-up never carries an entry's total beyond the port's cap; under flow-through the code does not hold top-ups to the cap.

`default_nettype none

package brp_pkg;

    // ============================================================
    // register indexes (byte address = index * 4)
    localparam logic [7:0] BRP_IDX_PRI_FIRST = 8'h48;
    localparam logic [7:0] BRP_IDX_SEC_FIRST = 8'h49;
    localparam logic [7:0] BRP_IDX_PRI_TOPUP = 8'h4A;
    localparam logic [7:0] BRP_IDX_SEC_TOPUP = 8'h4B;
    localparam logic [7:0] BRP_IDX_PRI_CAP   = 8'h4C;
    localparam logic [7:0] BRP_IDX_SEC_CAP   = 8'h4D;
    localparam logic [7:0] BRP_IDX_STATUS    = 8'h50;

    // ============================================================
    // field layout
    localparam int BRP_CNT_W      = 6;   // count field bits 5-0
    localparam int BRP_CNT_HI     = 5;
    localparam int BRP_CNT_LO     = 1;   // bit 0 is fixed zero
    localparam int BRP_ST_PRI_BSY = 0;
    localparam int BRP_ST_SEC_BSY = 1;

    // ============================================================
    // reset values
    localparam logic [5:0] BRP_RST_FIRST = 6'h10;
    localparam logic [5:0] BRP_RST_TOPUP = 6'h10;
    localparam logic [5:0] BRP_RST_CAP   = 6'h20;

    // ============================================================
    // sizing engine states
    typedef enum logic [0:0] {
        BRP_IDLE,
        BRP_RUN
    } brp_state_t;

endpackage

`default_nettype wire

/* rtl/brp_fetch_sizer.sv */
// Purpose: per-port engine that sizes first and top-up prefetches of one entry
// Assumes: start, consume, flow_through and finish come from logic on the same clock
// Notes:   one top-up at most per cycle; outputs are registered

`timescale 1ns/10ps
`default_nettype none

module brp_fetch_sizer
    import brp_pkg::*;
#(
    parameter int CW = BRP_CNT_W
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [CW-1:0] first_len,
    input  wire logic [CW-1:0] topup_len,
    input  wire logic [CW-1:0] cap_len,
    input  wire logic          start,
    input  wire logic          consume,
    input  wire logic          flow_through,
    input  wire logic          finish,
    output logic               fetch_issue,
    output logic [CW+1:0]      fetch_dwords,
    output logic               busy
);

    localparam int TW = CW + 2;

    // ============================================================
    // parameter check; refused at elaboration, before any logic is built
    if (CW < 2 || CW > 12) begin : g_bad_cw
        $error("brp_fetch_sizer: CW out of range");
    end

    brp_state_t    state, next_state;
    logic [TW-1:0] remaining, next_remaining;
    logic [TW-1:0] total, next_total;
    logic          next_fetch_issue;
    logic [TW-1:0] next_fetch_dwords;

    logic [TW-1:0] limit;
    logic [TW-1:0] first_w;
    logic [TW-1:0] topup_w;
    logic [TW:0]   total_after;
    logic          topup_allowed;

    // ============================================================
    // derived limits; zero cap is the full 2^CW double words
    assign limit         = (cap_len == '0) ? (TW'(1) << CW) : TW'(cap_len); // R11
    assign first_w       = TW'(first_len);                                 // R3
    assign topup_w       = TW'(topup_len);
    assign total_after   = {1'b0, total} + {1'b0, topup_w};
    // twice the top-up must fit the cap, else no top-up at all
    assign topup_allowed = ({1'b0, topup_len, 1'b0} <= limit); // R8 R9

    // next-state of the entry tracker
    always_comb begin
        logic [TW-1:0] rem_dec;
        rem_dec           = (consume && remaining != '0) ? remaining - TW'(1) : remaining;
        next_state        = state;
        next_remaining    = remaining;
        next_total        = total;
        next_fetch_issue  = 1'b0;
        next_fetch_dwords = fetch_dwords;
        unique case (state)
            BRP_IDLE: begin
                if (start) begin
                    // first fetch is clipped to the cap only without flow-through
                    if (!flow_through && first_w > limit) begin // R10 R15
                        next_fetch_dwords = limit;
                    end else begin
                        next_fetch_dwords = first_w; // R1 R2
                    end
                    next_fetch_issue = (next_fetch_dwords != '0);
                    next_remaining   = next_fetch_dwords;
                    next_total       = next_fetch_dwords;
                    next_state       = BRP_RUN;
                end
            end
            BRP_RUN: begin
                if (finish) begin
                    next_state     = BRP_IDLE;
                    next_remaining = '0;
                end else begin
                    next_remaining = rem_dec;
                    if (rem_dec < topup_w && topup_allowed
                        && (flow_through || total_after <= {1'b0, limit})) begin // R7 R16
                        next_fetch_issue  = 1'b1;
                        next_fetch_dwords = topup_w;
                        next_remaining    = rem_dec + topup_w;
                        if (!flow_through) begin
                            next_total = total_after[TW-1:0];
                        end
                    end
                end
            end
        endcase
    end

    // entry tracker registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= BRP_IDLE;
            remaining    <= '0;
            total        <= '0;
            fetch_issue  <= 1'b0;
            fetch_dwords <= '0;
            busy         <= 1'b0;
        end else begin
            state        <= next_state;
            remaining    <= next_remaining;
            total        <= next_total;
            fetch_issue  <= next_fetch_issue;
            fetch_dwords <= next_fetch_dwords;
            busy         <= (next_state == BRP_RUN);
        end
    end

    // ============================================================
    // checks
    a_first_length: assert property (@(posedge clk) disable iff (!rst_n) // R1 R2
        (state == BRP_IDLE && start && flow_through && first_len != '0)
        |=> (fetch_issue && fetch_dwords == TW'($past(first_len))))
        else $error("first fetch length wrong");

    a_topup_length: assert property (@(posedge clk) disable iff (!rst_n) // R7
        (fetch_issue && $past(state) == BRP_RUN) |-> (fetch_dwords == TW'($past(topup_len))))
        else $error("top-up length wrong");

    a_topup_gated: assert property (@(posedge clk) disable iff (!rst_n) // R8 R9
        (state == BRP_RUN && ({1'b0, topup_len, 1'b0} > limit)) |=> !fetch_issue)
        else $error("top-up issued above half the cap");

    a_cap_held: assert property (@(posedge clk) disable iff (!rst_n) // R10 R15 R16
        (fetch_issue && $past(state) == BRP_RUN && !$past(flow_through))
        |-> (total <= $past(limit)))
        else $error("entry total passed the cap");

    a_even_count: assert property (@(posedge clk) disable iff (!rst_n) // R3 R5
        fetch_issue |-> (fetch_dwords[0] == 1'b0))
        else $error("odd double word count issued");

    c_topup_seen: cover property (@(posedge clk) disable iff (!rst_n)
        fetch_issue && $past(state) == BRP_RUN);
    c_zero_cap: cover property (@(posedge clk) disable iff (!rst_n)
        state == BRP_RUN && cap_len == '0 && fetch_issue);

endmodule // brp_fetch_sizer

`default_nettype wire

/* rtl/brp_prefetch_sizing.sv */
// Purpose: AHB-Lite register file and two prefetch sizing engines of a bus bridge
// Assumes: port request strobes are synchronous to hclk; single word transfers
// Notes:   writes take no wait state, reads take one wait state
//
// Implementation choice: register access over AHB-Lite.

`timescale 1ns/10ps
`default_nettype none

module brp_prefetch_sizing
    import brp_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        pri_read_start,
    input  wire logic        pri_dword_taken,
    input  wire logic        pri_flow_through,
    input  wire logic        pri_read_done,
    output logic             pri_fetch_issue,
    output logic [7:0]       pri_fetch_dwords,
    input  wire logic        sec_read_start,
    input  wire logic        sec_dword_taken,
    input  wire logic        sec_flow_through,
    input  wire logic        sec_read_done,
    output logic             sec_fetch_issue,
    output logic [7:0]       sec_fetch_dwords
);

    localparam int FW = BRP_CNT_HI - BRP_CNT_LO + 1; // stored bits of a count

    // ============================================================
    // helpers
    // a count field as seen by logic: bit 0 forced zero
    function automatic logic [BRP_CNT_W-1:0] cnt_of(input logic [FW-1:0] f);
        cnt_of = {f, 1'b0}; // R5
    endfunction

    // a count register as read: bits 7-6 and above are zero
    function automatic logic [31:0] rd_of(input logic [FW-1:0] f);
        rd_of = {26'h0000000, f, 1'b0}; // R6
    endfunction

    // ============================================================
    // bus pipeline
    logic       dp_write, next_dp_write;
    logic       dp_read, next_dp_read;
    logic [7:0] dp_idx, next_dp_idx;
    logic       next_hreadyout;
    logic [31:0] next_hrdata;
    logic       accept;

    // transfer taken when selected, NONSEQ or SEQ and bus ready
    assign accept = hsel && htrans[1] && hready;

    // address phase capture; a read holds hready low for one cycle
    always_comb begin
        next_dp_write  = accept && hwrite;
        next_dp_read   = accept && !hwrite;
        next_dp_idx    = accept ? haddr[9:2] : dp_idx;
        // the wait state lets a write in the previous data phase land before the read
        next_hreadyout = !(accept && !hwrite);
        next_hrdata    = dp_read ? rd_mux(dp_idx) : hrdata;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write  <= 1'b0;
            dp_read   <= 1'b0;
            dp_idx    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end else begin
            dp_write  <= next_dp_write;
            dp_read   <= next_dp_read;
            dp_idx    <= next_dp_idx;
            hreadyout <= next_hreadyout;
            hresp     <= 1'b0; // always OKAY
            hrdata    <= next_hrdata;
        end
    end

    // ============================================================
    // count registers (bits 5-1 stored)
    logic [FW-1:0] pri_first, next_pri_first;
    logic [FW-1:0] sec_first, next_sec_first;
    logic [FW-1:0] pri_topup, next_pri_topup;
    logic [FW-1:0] sec_topup, next_sec_topup;
    logic [FW-1:0] pri_cap,   next_pri_cap;
    logic [FW-1:0] sec_cap,   next_sec_cap;
    logic          pri_busy;
    logic          sec_busy;

    // write in the data phase; bit 0 and bits 7-6 are dropped
    always_comb begin
        logic [FW-1:0] wf;
        wf             = hwdata[BRP_CNT_HI:BRP_CNT_LO]; // R5 R6
        next_pri_first = pri_first;
        next_sec_first = sec_first;
        next_pri_topup = pri_topup;
        next_sec_topup = sec_topup;
        next_pri_cap   = pri_cap;
        next_sec_cap   = sec_cap;
        if (dp_write) begin
            unique case (dp_idx)
                BRP_IDX_PRI_FIRST: next_pri_first = wf;
                BRP_IDX_SEC_FIRST: next_sec_first = wf;
                BRP_IDX_PRI_TOPUP: next_pri_topup = wf;
                BRP_IDX_SEC_TOPUP: next_sec_topup = wf;
                BRP_IDX_PRI_CAP:   next_pri_cap   = wf;
                BRP_IDX_SEC_CAP:   next_sec_cap   = wf;
                default: ;         // unmapped: ignored, still OKAY
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pri_first <= BRP_RST_FIRST[BRP_CNT_HI:BRP_CNT_LO]; // R13
            sec_first <= BRP_RST_FIRST[BRP_CNT_HI:BRP_CNT_LO]; // R13
            pri_topup <= BRP_RST_TOPUP[BRP_CNT_HI:BRP_CNT_LO]; // R13
            sec_topup <= BRP_RST_TOPUP[BRP_CNT_HI:BRP_CNT_LO]; // R13
            pri_cap   <= BRP_RST_CAP[BRP_CNT_HI:BRP_CNT_LO];   // R14
            sec_cap   <= BRP_RST_CAP[BRP_CNT_HI:BRP_CNT_LO];   // R15
        end else begin
            pri_first <= next_pri_first;
            sec_first <= next_sec_first;
            pri_topup <= next_pri_topup;
            sec_topup <= next_sec_topup;
            pri_cap   <= next_pri_cap;
            sec_cap   <= next_sec_cap;
        end
    end

    // read decode; unmapped words read zero
    function automatic logic [31:0] rd_mux(input logic [7:0] idx);
        unique case (idx)
            BRP_IDX_PRI_FIRST: rd_mux = rd_of(pri_first);
            BRP_IDX_SEC_FIRST: rd_mux = rd_of(sec_first);
            BRP_IDX_PRI_TOPUP: rd_mux = rd_of(pri_topup);
            BRP_IDX_SEC_TOPUP: rd_mux = rd_of(sec_topup);
            BRP_IDX_PRI_CAP:   rd_mux = rd_of(pri_cap);
            BRP_IDX_SEC_CAP:   rd_mux = rd_of(sec_cap);
            BRP_IDX_STATUS:    rd_mux = 32'(sec_busy) << BRP_ST_SEC_BSY
                                      | 32'(pri_busy) << BRP_ST_PRI_BSY;
            default:           rd_mux = 32'h00000000;
        endcase
    endfunction

    // ============================================================
    // sizing engines, one per port
    brp_fetch_sizer #(.CW(BRP_CNT_W)) u_pri (
        .clk          (hclk),
        .rst_n        (hresetn),
        .first_len    (cnt_of(pri_first)),
        .topup_len    (cnt_of(pri_topup)),
        .cap_len      (cnt_of(pri_cap)),
        .start        (pri_read_start),
        .consume      (pri_dword_taken),
        .flow_through (pri_flow_through),
        .finish       (pri_read_done),
        .fetch_issue  (pri_fetch_issue),
        .fetch_dwords (pri_fetch_dwords),
        .busy         (pri_busy)
    ); // R1 R8 R10

    brp_fetch_sizer #(.CW(BRP_CNT_W)) u_sec (
        .clk          (hclk),
        .rst_n        (hresetn),
        .first_len    (cnt_of(sec_first)),
        .topup_len    (cnt_of(sec_topup)),
        .cap_len      (cnt_of(sec_cap)),
        .start        (sec_read_start),
        .consume      (sec_dword_taken),
        .flow_through (sec_flow_through),
        .finish       (sec_read_done),
        .fetch_issue  (sec_fetch_issue),
        .fetch_dwords (sec_fetch_dwords),
        .busy         (sec_busy)
    ); // R2 R9 R15

    // ============================================================
    // checks
    a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        (hreadyout && $past(dp_read) && $past(dp_idx) != BRP_IDX_STATUS)
        |-> (hrdata[31:6] == 26'h0000000 && hrdata[0] == 1'b0))
        else $error("reserved or bit 0 read nonzero");

    a_read_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        (dp_write && dp_idx == BRP_IDX_PRI_TOPUP)
        |=> (pri_topup == $past(hwdata[BRP_CNT_HI:BRP_CNT_LO])))
        else $error("count write lost");

    a_cap_write: assert property (@(posedge hclk) disable iff (!hresetn) // R5 R15
        (dp_write && dp_idx == BRP_IDX_SEC_CAP)
        |=> (sec_cap == $past(hwdata[BRP_CNT_HI:BRP_CNT_LO])))
        else $error("secondary cap write lost");

    c_write_read: cover property (@(posedge hclk) disable iff (!hresetn)
        dp_write ##1 (accept && !hwrite));
    c_both_busy: cover property (@(posedge hclk) disable iff (!hresetn)
        pri_busy && sec_busy);

endmodule // brp_prefetch_sizing

`default_nettype wire

/* bench/brp_port_model.sv */
// Purpose: far-side initiator of one port: opens a prefetchable read, takes dwords, closes it
// Assumes: bench changes go, ft, n_take and gap just after a rising edge of clk
// Notes:   never takes a dword that has not been fetched, like a real target queue

`timescale 1ns/10ps
`default_nettype none

module brp_port_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic       ft,
    input  wire logic [7:0] n_take,
    input  wire logic [3:0] gap,
    input  wire logic       fetch_issue,
    input  wire logic [7:0] fetch_dwords,
    output logic            read_start,
    output logic            dword_taken,
    output logic            flow_through,
    output logic            read_done,
    output logic            done,
    output logic [7:0]      first_len,
    output logic [8:0]      total
);
    logic       active;
    logic [8:0] taken;
    logic [3:0] wait_cnt;
    logic [3:0] stall;

    // ============================================================
    // entry sequencer; a stall limit closes the entry once the fetcher stops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {read_start, dword_taken, flow_through, read_done, done, active} <= '0;
            {first_len, total, taken, wait_cnt, stall} <= '0;
        end else begin
            read_start   <= 1'b0;
            dword_taken  <= 1'b0;
            read_done    <= 1'b0;
            flow_through <= ft;
            if (fetch_issue) begin
                total <= total + {1'b0, fetch_dwords};
                if (total == 9'h0) first_len <= fetch_dwords;
            end
            if (go && !active) begin
                active     <= 1'b1;
                read_start <= 1'b1;
                done       <= 1'b0;
                total      <= '0;
                taken      <= '0;
                stall      <= '0;
                wait_cnt   <= gap;
            end else if (active) begin
                if (taken == {1'b0, n_take} || stall == 4'hF) begin
                    read_done <= 1'b1;
                    active    <= 1'b0;
                    done      <= 1'b1;
                end else if (wait_cnt != 4'h0) begin
                    wait_cnt <= wait_cnt - 4'h1;
                end else if (taken < total) begin
                    dword_taken <= 1'b1;
                    taken       <= taken + 9'h1;
                    wait_cnt    <= gap;
                    stall       <= '0;
                end else begin
                    stall <= stall + 4'h1;
                end
            end
        end
    end
endmodule // brp_port_model

`default_nettype wire

/* bench/tb.sv */
// Purpose: self-checking bench of the read prefetch sizing block
// Assumes: one AHB-Lite master, single word transfers, one port model per side
// Notes:   register cases run from a table; engine cases are hand-written

`timescale 1ns/10ps
`default_nettype none

module tb;
    import brp_pkg::*;

    typedef struct packed {
        logic        wr;
        logic [7:0]  idx;
        logic [31:0] wd;
        logic [31:0] exp;
    } brp_row_t;

    localparam int NROWS   = 14;
    localparam int CYC_MAX = 20000;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = '0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = '0;
    logic        hreadyout, hresp;
    logic [31:0] hrdata, rd;
    logic        go_p = 1'b0, go_s = 1'b0, ft = 1'b0;
    logic [7:0]  n_take = '0;
    logic [3:0]  gap = '0;
    logic        p_start, p_take, p_ft, p_done, p_issue, done_p;
    logic        s_start, s_take, s_ft, s_done, s_issue, done_s;
    logic [7:0]  p_dw, s_dw, first_p, first_s;
    logic [8:0]  total_p, total_s;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;

    // reset reads first, then write and read back: bit 0 and bits 7-6 stay zero
    brp_row_t rows [NROWS] = '{
        '{1'b0, BRP_IDX_PRI_FIRST, 32'h0, 32'h10}, '{1'b0, BRP_IDX_SEC_FIRST, 32'h0, 32'h10},
        '{1'b0, BRP_IDX_PRI_TOPUP, 32'h0, 32'h10}, '{1'b0, BRP_IDX_SEC_TOPUP, 32'h0, 32'h10},
        '{1'b0, BRP_IDX_PRI_CAP, 32'h0, 32'h20}, '{1'b0, BRP_IDX_SEC_CAP, 32'h0, 32'h20},
        '{1'b0, BRP_IDX_STATUS, 32'h0, 32'h0}, '{1'b1, BRP_IDX_PRI_FIRST, 32'hFFFFFFFF, 32'h3E},
        '{1'b1, BRP_IDX_SEC_FIRST, 32'h01, 32'h0}, '{1'b1, BRP_IDX_PRI_TOPUP, 32'hC4, 32'h04},
        '{1'b1, BRP_IDX_SEC_TOPUP, 32'h23, 32'h22}, '{1'b1, BRP_IDX_PRI_CAP, 32'h7F, 32'h3E},
        '{1'b1, BRP_IDX_SEC_CAP, 32'h40, 32'h0}, '{1'b1, 8'h4E, 32'hFF, 32'h0}
    };

    brp_prefetch_sizing brp_prefetch_sizing_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pri_read_start(p_start), .pri_dword_taken(p_take), .pri_flow_through(p_ft),
        .pri_read_done(p_done), .pri_fetch_issue(p_issue), .pri_fetch_dwords(p_dw),
        .sec_read_start(s_start), .sec_dword_taken(s_take), .sec_flow_through(s_ft),
        .sec_read_done(s_done), .sec_fetch_issue(s_issue), .sec_fetch_dwords(s_dw));

    brp_port_model pri_model_i (.clk(hclk), .rst_n(hresetn), .go(go_p), .ft(ft),
        .n_take(n_take), .gap(gap), .fetch_issue(p_issue), .fetch_dwords(p_dw),
        .read_start(p_start), .dword_taken(p_take), .flow_through(p_ft), .read_done(p_done),
        .done(done_p), .first_len(first_p), .total(total_p));

    brp_port_model sec_model_i (.clk(hclk), .rst_n(hresetn), .go(go_s), .ft(ft),
        .n_take(n_take), .gap(gap), .fetch_issue(s_issue), .fetch_dwords(s_dw),
        .read_start(s_start), .dword_taken(s_take), .flow_through(s_ft), .read_done(s_done),
        .done(done_s), .first_len(first_s), .total(total_s));

    // ============================================================
    // clock and hang guard
    initial begin
        forever #2.5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc++;
        if (cyc == CYC_MAX) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ============================================================
    // AHB-Lite master; the wait is bounded so a stuck slave cannot hang the run
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (n == 50) chk("hready", 32'h1, 32'(hreadyout));
    endtask

    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask

    // lengths given here are powers of two and caps are even
    task automatic cfg(input logic sec, input logic [31:0] f, input logic [31:0] t,
                       input logic [31:0] c);
        xfer(1'b1, sec ? BRP_IDX_SEC_FIRST : BRP_IDX_PRI_FIRST, f);
        xfer(1'b1, sec ? BRP_IDX_SEC_TOPUP : BRP_IDX_PRI_TOPUP, t);
        xfer(1'b1, sec ? BRP_IDX_SEC_CAP : BRP_IDX_PRI_CAP, c);
    endtask

    // one entry through a port model, then first and total fetch lengths compared
    task automatic run_entry(input logic sec, input logic f, input logic [7:0] n,
                             input logic [3:0] g, input logic [8:0] ef, input logic [8:0] et);
        int k;
        k = 0;
        ft     <= f;
        n_take <= n;
        gap    <= g;
        if (sec) go_s <= 1'b1;
        else go_p <= 1'b1;
        @(posedge hclk);
        go_s <= 1'b0;
        go_p <= 1'b0;
        // the entry runs far longer than one read, so its busy bit must show
        xfer(1'b0, BRP_IDX_STATUS, 32'h0);
        chk("status busy", sec ? 32'h2 : 32'h1, rd);
        @(posedge hclk);
        while ((sec ? done_s : done_p) !== 1'b1 && k < 2000) begin
            @(posedge hclk);
            k++;
        end
        chk("entry done", 32'h1, 32'(sec ? done_s : done_p));
        chk("first fetch", 32'(ef), 32'(sec ? first_s : first_p));
        chk("total fetch", 32'(et), 32'(sec ? total_s : total_p));
    endtask

    // ============================================================
    // main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < NROWS; i++) begin
            if (rows[i].wr) xfer(1'b1, rows[i].idx, rows[i].wd);
            xfer(1'b0, rows[i].idx, 32'h0);
            chk("register", rows[i].exp, rd);
        end
        // reset in mid-run must bring the primary top-up field back to its reset value
        xfer(1'b1, BRP_IDX_PRI_TOPUP, 32'h4);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, BRP_IDX_PRI_TOPUP, 32'h0);
        chk("topup after reset", 32'h10, rd);
        cfg(1'b0, 32'h10, 32'h10, 32'h20);
        run_entry(1'b0, 1'b0, 8'd40, 4'd3, 9'd16, 9'd32);
        cfg(1'b1, 32'h08, 32'h04, 32'h10);
        run_entry(1'b1, 1'b0, 8'd30, 4'd3, 9'd8, 9'd16);
        cfg(1'b0, 32'h10, 32'h10, 32'h1E);
        run_entry(1'b0, 1'b0, 8'd40, 4'd3, 9'd16, 9'd16);
        cfg(1'b1, 32'h08, 32'h08, 32'h0E);
        run_entry(1'b1, 1'b0, 8'd30, 4'd1, 9'd8, 9'd8);
        cfg(1'b0, 32'h10, 32'h10, 32'h00);
        run_entry(1'b0, 1'b0, 8'd80, 4'd3, 9'd16, 9'd64);
        cfg(1'b0, 32'h10, 32'h10, 32'h20);
        run_entry(1'b0, 1'b1, 8'd60, 4'd3, 9'd16, 9'd80);
        xfer(1'b0, BRP_IDX_STATUS, 32'h0);
        chk("status idle", 32'h0, rd);
        close_out();
    end
endmodule // tb

`default_nettype wire
